// >>> design/logpage_builder.sv
// builds the reservation notification and sanitize status log pages
// assumes one 50 MHz clock, same-domain request and event inputs,
// and a retention store outside that holds the sanitize page over power loss
`include "logpage_params.svh"
`default_nettype none

module logpage_builder #(
	parameter int QDEPTH = 8,
	parameter int QAW    = 3
) (
	input  wire logic                      CLK,
	input  wire logic                      RSTN,
	input  wire logic                      EVT_VALID,
	input  wire logic [7:0]                EVT_TYPE,
	input  wire logic [31:0]               EVT_NSID,
	input  wire logic                      PAGE_REQ,
	input  wire logic [7:0]                PAGE_LID,
	output logic                           PAGE_BUSY,
	output logic                           PAGE_ACK,
	output logic                           PAGE_OK,
	input  wire logic                      DW_RD,
	input  wire logic [6:0]                DW_IDX,
	output logic                           DW_VALID,
	output logic [31:0]                    DW_DATA,
	input  wire logic [31:0]               SANICAP,
	input  wire logic                      NV_VALID,
	input  wire logpage_pkg::san_page_s    NV_PAGE,
	input  wire logic                      SAN_UPDATE,
	input  wire logpage_pkg::san_page_s    SAN_IN,
	output logpage_pkg::san_page_s         SAN_PERSIST,
	input  wire logic                      CTRL_ENABLE,
	output logic                           CTRL_READY
);

	// ******************************************************
	// helpers
	// ******************************************************

	// only the three defined non-empty types may enter a page
	function automatic logic type_legal(input logic [7:0] t);
		return (t == `NTYPE_REG_PREEMPT) || (t == `NTYPE_RSV_RELEASE)
			|| (t == `NTYPE_RSV_PREEMPT);
	endfunction : type_legal

	// 64-bit count wraps past the top to one, never to zero
	function automatic logic [63:0] count_step(input logic [63:0] c);
		return (c == `COUNT_MAX) ? `COUNT_WRAP : c + 64'h1;
	endfunction : count_step

	// ******************************************************
	// notification queue
	// ******************************************************

	logic [QAW-1:0]            wr_ptr;
	logic [QAW-1:0]            rd_ptr;
	logic [QAW:0]              occ;
	logic [63:0]               ncount;
	logpage_pkg::notif_entry_s mem_rdata;
	logpage_pkg::page_state_e  state;
	logic                      push;
	logic                      pop;
	logic                      qfull;

	assign qfull = (occ == (QAW+1)'(QDEPTH)) ? 1'b1 : 1'b0;
	// full notifications are dropped but still counted
	assign push = EVT_VALID && type_legal(EVT_TYPE) && !qfull;
	assign pop  = (state == logpage_pkg::PG_IDLE) && PAGE_REQ
		&& (PAGE_LID == `LID_NOTIF) && (occ != '0);

	// counter moves on every legal-type event, queued or lost
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			ncount <= `COUNT_RESET;
		end else if (EVT_VALID && type_legal(EVT_TYPE)) begin
			ncount <= count_step(ncount);
		end
	end

	// queue pointers and occupancy
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			occ    <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == QAW'(QDEPTH - 1)) ? '0 : wr_ptr + QAW'(1);
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == QAW'(QDEPTH - 1)) ? '0 : rd_ptr + QAW'(1);
			end
			occ <= occ + (QAW+1)'(push) - (QAW+1)'(pop);
		end
	end

	notif_mem #(
		.DEPTH (QDEPTH),
		.AW    (QAW)
	) u_mem (
		.clk     (CLK),
		.wr_en   (push),
		.wr_addr (wr_ptr),
		.wr_data ({count_step(ncount), EVT_TYPE, EVT_NSID}),
		.rd_addr (rd_ptr),
		.rd_data (mem_rdata)
	);

	// ******************************************************
	// page fetch sequencing
	// ******************************************************

	logic [7:0]                sel_lid;
	logic                      sel_ok;
	logic                      sel_full;
	logic [7:0]                avail;
	logpage_pkg::notif_entry_s snap;
	logic                      san_valid;
	logic                      san_sup;

	assign san_sup   = (SANICAP != '0);
	assign PAGE_BUSY = (state != logpage_pkg::PG_IDLE);

	// a request while busy is ignored; the pop waits one cycle for memory data
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			state    <= logpage_pkg::PG_IDLE;
			sel_lid  <= 8'h00;
			sel_ok   <= 1'b0;
			sel_full <= 1'b0;
			avail    <= 8'h00;
			PAGE_ACK <= 1'b0;
			PAGE_OK  <= 1'b0;
		end else begin
			PAGE_ACK <= 1'b0;
			unique case (state)
				logpage_pkg::PG_IDLE: begin
					if (PAGE_REQ) begin
						sel_lid  <= PAGE_LID;
						sel_full <= pop;
						// reserved when no sanitize support
						sel_ok   <= (PAGE_LID == `LID_NOTIF)
							|| ((PAGE_LID == `LID_SANITIZE) && san_sup);
						avail    <= (32'(occ) > 32'h0000_0100) ? `AVAIL_SAT
							: (occ == '0) ? 8'h00 : 8'((occ - 1'b1));
						state    <= pop ? logpage_pkg::PG_FETCH : logpage_pkg::PG_ACK;
					end
				end
				logpage_pkg::PG_FETCH: begin
					state <= logpage_pkg::PG_ACK;
				end
				logpage_pkg::PG_ACK: begin
					PAGE_ACK <= 1'b1;
					PAGE_OK  <= sel_ok;
					state    <= logpage_pkg::PG_IDLE;
				end
			endcase
		end
	end

	// snapshot of the popped entry; an empty read leaves every field zero
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			snap <= '0;
		end else if (state == logpage_pkg::PG_IDLE && PAGE_REQ) begin
			snap <= '0;
		end else if (state == logpage_pkg::PG_FETCH && sel_full) begin
			snap <= mem_rdata;
		end
	end

	// ******************************************************
	// retained sanitize page
	// ******************************************************

	// no reset here: the content must outlive a controller reset
	always_ff @(posedge CLK) begin
		if (SAN_UPDATE) begin
			SAN_PERSIST <= SAN_IN;
		end else if (!san_valid && NV_VALID) begin
			SAN_PERSIST <= NV_PAGE;
		end
	end

	// ready only after the page has been restored or written
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			san_valid <= 1'b0;
		end else if (SAN_UPDATE || NV_VALID) begin
			san_valid <= 1'b1;
		end
	end

	assign CTRL_READY = CTRL_ENABLE && san_valid;

	// ******************************************************
	// dword read port
	// ******************************************************

	logic [31:0] next_dw;
	logic [15:0] prog;

	// progress only means something while a sanitize runs
	assign prog = (SAN_PERSIST.sanitize_status_field[2:0] == `SAN_STATUS_RUNNING)
		? SAN_PERSIST.sanitize_progress_field : `SAN_PROGRESS_NONE;

	// unnamed dwords and reserved bytes read zero
	always_comb begin
		next_dw = 32'h0000_0000;
		if (sel_ok && sel_lid == `LID_NOTIF) begin
			unique case (DW_IDX)
				`NOTIF_DW_CNT_LO: next_dw = snap.count[31:0];
				`NOTIF_DW_CNT_HI: next_dw = snap.count[63:32];
				`NOTIF_DW_TYPE:   next_dw = {16'h0000, avail, snap.ntype};
				`NOTIF_DW_NSID:   next_dw = snap.nsid;
				default:          next_dw = 32'h0000_0000;
			endcase
			if (!sel_full) begin
				next_dw = 32'h0000_0000;
			end
		end else if (sel_ok && sel_lid == `LID_SANITIZE) begin
			unique case (DW_IDX)
				`SAN_DW_STAT:  next_dw = {SAN_PERSIST.sanitize_status_field, prog};
				`SAN_DW_CDW10: next_dw = SAN_PERSIST.cdw10;
				`SAN_DW_OW:    next_dw = SAN_PERSIST.est_overwrite;
				`SAN_DW_BE:    next_dw = SAN_PERSIST.est_block;
				`SAN_DW_CE:    next_dw = SAN_PERSIST.est_crypto;
				default:       next_dw = 32'h0000_0000;
			endcase
		end
	end

	// read data one cycle after the strobe
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			DW_VALID <= 1'b0;
			DW_DATA  <= 32'h0000_0000;
		end else begin
			DW_VALID <= DW_RD;
			if (DW_RD) begin
				DW_DATA <= next_dw;
			end
		end
	end

	// ******************************************************
	// checks
	// ******************************************************

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RSTN);

	// expected further-page count for the occupancy seen at the taking edge
	function automatic logic [7:0] occ_past_m1(input logic [QAW:0] o);
		return (32'(o) > 32'h0000_0100) ? `AVAIL_SAT : 8'(o - 1'b1);
	endfunction : occ_past_m1

	a_avail_saturates: assert property (
		PAGE_REQ && !PAGE_BUSY && occ > (QAW+1)'(0) |=> avail == occ_past_m1($past(occ)))
		else $error("further-page count wrong");

	a_empty_zero_avail: assert property (
		PAGE_REQ && !PAGE_BUSY && occ == '0 |=> avail == 8'h00)
		else $error("empty queue must report zero further pages");

	a_nsid_dword: assert property (
		DW_RD && sel_ok && sel_lid == `LID_NOTIF && sel_full && DW_IDX == `NOTIF_DW_NSID
		|=> DW_DATA == $past(snap.nsid))
		else $error("namespace id dword wrong");

	a_san_reserved: assert property (
		PAGE_REQ && !PAGE_BUSY && PAGE_LID == `LID_SANITIZE && SANICAP == '0
		|-> ##2 PAGE_ACK && !PAGE_OK)
		else $error("sanitize page accepted without capability");

	a_san_supported: assert property (
		PAGE_REQ && !PAGE_BUSY && PAGE_LID == `LID_SANITIZE && SANICAP != '0
		|-> ##2 PAGE_ACK && PAGE_OK)
		else $error("sanitize page refused with capability");

	// whatever made the page valid must be what the page now holds
	a_ready_valid: assert property (
		SAN_UPDATE || (!san_valid && NV_VALID)
		|=> san_valid && SAN_PERSIST == ($past(SAN_UPDATE) ? $past(SAN_IN) : $past(NV_PAGE)))
		else $error("sanitize page not loaded when it became valid");

	a_prog_forced: assert property (
		DW_RD && sel_ok && sel_lid == `LID_SANITIZE && DW_IDX == `SAN_DW_STAT
		&& SAN_PERSIST.sanitize_status_field[2:0] != `SAN_STATUS_RUNNING
		|=> DW_DATA[15:0] == `SAN_PROGRESS_NONE)
		else $error("progress not forced to all ones");

	a_count_steps: assert property (
		EVT_VALID && type_legal(EVT_TYPE) |=> ncount != $past(ncount) && ncount != '0)
		else $error("notification counter did not advance");

	a_pop_once: assert property (
		pop |=> occ == $past(occ) - 1'b1 + (QAW+1)'($past(push)))
		else $error("read did not remove oldest entry");

	a_no_bad_type: assert property (
		DW_RD && sel_lid == `LID_NOTIF && DW_IDX == `NOTIF_DW_TYPE
		|=> DW_DATA[7:0] <= `NTYPE_RSV_PREEMPT && DW_DATA[31:16] == 16'h0000)
		else $error("illegal type or nonzero reserved bytes");

endmodule : logpage_builder

`default_nettype wire

// >>> pkg/logpage_params.svh
// timing-free constants for the reservation notification and sanitize status pages
// assumes inclusion by the builder design file only, by bare name
`ifndef LOGPAGE_PARAMS_SVH
`define LOGPAGE_PARAMS_SVH

// log identifiers
`define LID_NOTIF        8'h80
`define LID_SANITIZE     8'h81

// notification types
`define NTYPE_EMPTY      8'h00
`define NTYPE_REG_PREEMPT 8'h01
`define NTYPE_RSV_RELEASE 8'h02
`define NTYPE_RSV_PREEMPT 8'h03

// field values and limits
`define AVAIL_SAT        8'hFF
`define SAN_STATUS_RUNNING 3'h2
`define SAN_PROGRESS_NONE  16'hFFFF
`define COUNT_MAX        64'hFFFF_FFFF_FFFF_FFFF
`define COUNT_WRAP       64'h0000_0000_0000_0001
`define COUNT_RESET      64'h0000_0000_0000_0000

// dword positions inside the pages
`define NOTIF_DW_CNT_LO  7'h00
`define NOTIF_DW_CNT_HI  7'h01
`define NOTIF_DW_TYPE    7'h02
`define NOTIF_DW_NSID    7'h03
`define SAN_DW_STAT      7'h00
`define SAN_DW_CDW10     7'h01
`define SAN_DW_OW        7'h02
`define SAN_DW_BE        7'h03
`define SAN_DW_CE        7'h04

`endif

// >>> pkg/logpage_pkg.sv
// types shared by the log page builder and its notification store
// assumes logpage_params.svh sits beside it on the include path
`default_nettype none

package logpage_pkg;

	// one queued reservation notification
	typedef struct packed {
		logic [63:0] count;
		logic [7:0]  ntype;
		logic [31:0] nsid;
	} notif_entry_s;

	// whole retained sanitize status page content
	typedef struct packed {
		logic [31:0] est_crypto;
		logic [31:0] est_block;
		logic [31:0] est_overwrite;
		logic [31:0] cdw10;
		logic [15:0] sanitize_status_field;
		logic [15:0] sanitize_progress_field;
	} san_page_s;

	// page fetch sequencing
	typedef enum logic [1:0] {
		PG_IDLE,
		PG_FETCH,
		PG_ACK
	} page_state_e;

endpackage : logpage_pkg

`default_nettype wire

// >>> design/notif_store.sv
// no module here: queued notifications are stored by notif_mem
// assumes nothing; this file elaborates to nothing
`default_nettype none

`default_nettype wire

// >>> design/notif_mem.sv
// memory of queued notifications, registered read data
// assumes the caller never writes and reads one slot in the same cycle
`default_nettype none

module notif_mem #(
	parameter int DEPTH = 8,
	parameter int AW    = 3
) (
	input  wire logic                       clk,
	input  wire logic                       wr_en,
	input  wire logic [AW-1:0]              wr_addr,
	input  wire logpage_pkg::notif_entry_s  wr_data,
	input  wire logic [AW-1:0]              rd_addr,
	output var  logpage_pkg::notif_entry_s  rd_data
);

	logpage_pkg::notif_entry_s mem [DEPTH];

	// write port
	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	// read data always leaves through a register
	always_ff @(posedge clk) begin
		rd_data <= mem[rd_addr];
	end

endmodule : notif_mem

`default_nettype wire

// >>> test/host_model.sv
// host model: issues log page fetches and dword reads of the fetched page
// assumes the bench calls its tasks and nothing else drives these pins
`default_nettype none

module host_model (
	input  wire logic        clk,
	input  wire logic        page_busy,
	input  wire logic        page_ack,
	input  wire logic        page_ok,
	input  wire logic        dw_valid,
	input  wire logic [31:0] dw_data,
	output var  logic        page_req,
	output var  logic [7:0]  page_lid,
	output var  logic        dw_rd,
	output var  logic [6:0]  dw_idx
);
	timeunit 1ns;
	timeprecision 1ns;

	// ****************************************
	// fetch and dword read
	// ****************************************
	// idle buses show the inverse of the last value so stale data never passes
	initial begin
		page_req = 1'b0;
		page_lid = 8'h00;
		dw_rd = 1'b0;
		dw_idx = 7'h00;
	end

	// one fetch; waits out a busy builder, then the acknowledge, both bounded
	task automatic fetch(input logic [7:0] lid, output logic ok, output logic done,
		output logic busy);
		done = 1'b0;
		ok = 1'b0;
		busy = 1'b0;
		@(negedge clk);
		for (int n = 0; n < 20 && page_busy !== 1'b0; n++) begin
			@(negedge clk);
		end
		page_req = 1'b1;
		page_lid = lid;
		@(negedge clk);
		page_req = 1'b0;
		page_lid = ~lid;
		// a taken request must show busy one cycle later
		busy = page_busy;
		for (int n = 0; n < 8 && !done; n++) begin
			if (page_ack === 1'b1) begin
				done = 1'b1;
				ok = page_ok;
			end else begin
				@(negedge clk);
			end
		end
	endtask : fetch

	// read data is taken in the single cycle that the valid pulse stands
	task automatic read_dw(input logic [6:0] idx, output logic [31:0] data);
		@(negedge clk);
		dw_rd = 1'b1;
		dw_idx = idx;
		@(negedge clk);
		dw_rd = 1'b0;
		dw_idx = ~idx;
		data = (dw_valid === 1'b1) ? dw_data : 32'hXXXX_XXXX;
	endtask : read_dw

endmodule : host_model

`default_nettype wire

// >>> test/tb_top.sv
// bench for the log page builder: events, page fetches, sanitize retention
// assumes host_model drives the fetch pins; the bench plays retention store
`default_nettype none

module tb_top;
	timeunit 1ns;
	timeprecision 1ns;

	// ****************************************
	// signals and instances
	// ****************************************
	logic                   clk, rstn, evt_valid, page_req, page_busy, page_ack, page_ok;
	logic                   dw_rd, dw_valid, san_update, nv_valid, ctrl_enable, ctrl_ready;
	logic [7:0]             evt_type, page_lid;
	logic [6:0]             dw_idx;
	logic [31:0]            evt_nsid, dw_data, sanicap;
	logpage_pkg::san_page_s nv_page, san_in, san_persist, p1, p2;
	int                     fails, checks;

	// deep queue so the further-pages count can pass its 255 ceiling
	logpage_builder #(.QDEPTH(512), .QAW(9)) u_logpage_builder (
		.CLK(clk), .RSTN(rstn), .EVT_VALID(evt_valid), .EVT_TYPE(evt_type),
		.EVT_NSID(evt_nsid), .PAGE_REQ(page_req), .PAGE_LID(page_lid),
		.PAGE_BUSY(page_busy), .PAGE_ACK(page_ack), .PAGE_OK(page_ok), .DW_RD(dw_rd),
		.DW_IDX(dw_idx), .DW_VALID(dw_valid), .DW_DATA(dw_data), .SANICAP(sanicap),
		.NV_VALID(nv_valid), .NV_PAGE(nv_page), .SAN_UPDATE(san_update), .SAN_IN(san_in),
		.SAN_PERSIST(san_persist), .CTRL_ENABLE(ctrl_enable), .CTRL_READY(ctrl_ready));

	host_model u_host_model (
		.clk(clk), .page_busy(page_busy), .page_ack(page_ack), .page_ok(page_ok),
		.dw_valid(dw_valid), .dw_data(dw_data), .page_req(page_req),
		.page_lid(page_lid), .dw_rd(dw_rd), .dw_idx(dw_idx));

	// 50 MHz clock
	always #10 clk = ~clk;

	// ****************************************
	// helpers
	// ****************************************
	task automatic chk(input string what, input logic [159:0] exp, input logic [159:0] got);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// fetch a page and compare its first sixteen dwords; dwords 5 and up read zero
	task automatic page_check(input logic [7:0] lid, input logic ok_exp, input logic [159:0] e);
		logic        ok;
		logic        done;
		logic        busy;
		logic [31:0] d;
		u_host_model.fetch(lid, ok, done, busy);
		chk("fetch done", {159'h0, 1'h1}, {159'h0, done});
		// a lost acknowledge ends the run at once
		if (done !== 1'b1) begin
			finish_test();
		end
		chk("page busy", {159'h0, 1'h1}, {159'h0, busy});
		chk("page ok", {159'h0, ok_exp}, {159'h0, ok});
		for (int i = 0; i < 16; i++) begin
			u_host_model.read_dw(7'(i), d);
			chk("page dword", (i < 5) ? {128'h0, e[32*i +: 32]} : 160'h0, {128'h0, d});
		end
	endtask : page_check

	// progress reads as none unless a sanitize is running
	function automatic logic [159:0] san_exp(input logpage_pkg::san_page_s p);
		san_exp = p;
		if (p.sanitize_status_field[2:0] !== 3'h2) begin
			san_exp[15:0] = 16'hFFFF;
		end
	endfunction : san_exp

	function automatic logic [159:0] notif_exp(input logic [63:0] c, input logic [7:0] av,
		input logic [7:0] ty, input logic [31:0] ns);
		notif_exp = {32'h0, ns, 16'h0, av, ty, c};
	endfunction : notif_exp

	task automatic evt(input logic [7:0] ty, input logic [31:0] ns);
		@(negedge clk);
		evt_valid = 1'b1;
		evt_type = ty;
		evt_nsid = ns;
		@(negedge clk);
		evt_valid = 1'b0;
		evt_nsid = ~ns;
	endtask : evt

	task automatic san_up(input logpage_pkg::san_page_s p);
		@(negedge clk);
		san_update = 1'b1;
		san_in = p;
		@(negedge clk);
		san_update = 1'b0;
	endtask : san_up

	task automatic do_reset();
		@(negedge clk);
		rstn = 1'b0;
		repeat (10) @(negedge clk);
		rstn = 1'b1;
	endtask : do_reset

	task automatic finish_test();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : finish_test

	// ****************************************
	// scenarios
	// ****************************************
	task automatic test_restore();
		for (int i = 0; i < 8 && ctrl_ready !== 1'b1; i++) begin
			@(negedge clk);
		end
		chk("ready", {159'h0, 1'h1}, {159'h0, ctrl_ready});
		// a restore that never comes ends the run at once
		if (ctrl_ready !== 1'b1) begin
			finish_test();
		end
		page_check(8'h81, 1'h1, san_exp(nv_page));
		ctrl_enable = 1'b0;
		#1 chk("ready off", 160'h0, {159'h0, ctrl_ready});
		@(negedge clk);
		ctrl_enable = 1'b1;
		nv_valid = 1'b0;
		$display("test restore done");
	endtask : test_restore

	// illegal types 04h, FFh and 00h must neither queue nor count
	task automatic test_notif();
		page_check(8'h80, 1'h1, 160'h0);
		evt(8'h01, 32'h0000_00A1);
		evt(8'h04, 32'h0000_00EE);
		evt(8'h02, 32'h0000_00B2);
		evt(8'hFF, 32'h0000_00EF);
		evt(8'h00, 32'h0000_00E0);
		evt(8'h03, 32'h0000_00C3);
		page_check(8'h80, 1'h1, notif_exp(64'h1, 8'h02, 8'h01, 32'hA1));
		page_check(8'h80, 1'h1, notif_exp(64'h2, 8'h01, 8'h02, 32'hB2));
		page_check(8'h80, 1'h1, notif_exp(64'h3, 8'h00, 8'h03, 32'hC3));
		page_check(8'h80, 1'h1, 160'h0);
		$display("test notif done");
	endtask : test_notif

	task automatic test_sanitize();
		p1 = {32'hC0DE_0004, 32'hB10C_0003, 32'h0E0E_0002, 32'hCD10_0001, 16'h0102, 16'h8000};
		p2 = p1;
		p2.sanitize_status_field = 16'h0001;
		sanicap = 32'h0;
		san_up(p1);
		page_check(8'h81, 1'h0, 160'h0);
		sanicap = 32'h0000_0002;
		page_check(8'h81, 1'h1, san_exp(p1));
		san_up(p2);
		page_check(8'h81, 1'h1, san_exp(p2));
		$display("test sanitize done");
	endtask : test_sanitize

	// no restore offered: the page must ride through reset on its own
	task automatic test_persist();
		do_reset();
		chk("retained page", p2, san_persist);
		page_check(8'h81, 1'h1, san_exp(p2));
		$display("test persist done");
	endtask : test_persist

	task automatic test_saturate();
		@(negedge clk);
		for (int i = 0; i < 258; i++) begin
			evt_valid = 1'b1;
			evt_type = 8'h01;
			evt_nsid = 32'(i);
			@(negedge clk);
		end
		evt_valid = 1'b0;
		for (int k = 0; k < 4; k++) begin
			page_check(8'h80, 1'h1, notif_exp(64'(k + 1), (k < 3) ? 8'hFF : 8'hFE, 8'h01,
				32'(k)));
		end
		$display("test saturate done");
	endtask : test_saturate

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		clk = 1'b0;
		rstn = 1'b0;
		evt_valid = 1'b0;
		evt_type = 8'h00;
		evt_nsid = 32'h0;
		san_update = 1'b0;
		san_in = '0;
		sanicap = 32'h0000_0001;
		ctrl_enable = 1'b1;
		nv_valid = 1'b1;
		nv_page = {32'h0000_0030, 32'h0000_0020, 32'h0000_0010, 32'h0000_0007, 16'h0003,
			16'h1111};
		fails = 0;
		checks = 0;
		repeat (10) @(negedge clk);
		rstn = 1'b1;
		test_restore();
		test_notif();
		test_sanitize();
		test_persist();
		test_saturate();
		finish_test();
	end

endmodule : tb_top

`default_nettype wire
